/* include/ext_osc_pkg.sv */
package ext_osc_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int EVT_W  = 2;

  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h3;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_VALID_BIT = 7;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_RSVD_BIT  = 3;
  localparam int CTRL_FREQ_LSB  = 0;
  localparam int MODE_W         = 3;
  localparam int FREQ_W         = 3;

  localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RESET  = 3'h0;
  localparam logic [FREQ_W-1:0] FREQ_RESET  = 3'h0;
  localparam logic [EVT_W-1:0]  EVT_RESET   = 2'h0;

  // ---------------------------------------------------------------
  // interrupt event bits
  // ---------------------------------------------------------------
  localparam int EVT_VALID_BIT = 0;
  localparam int EVT_LOST_BIT  = 1;

  // ---------------------------------------------------------------
  // oscillator mode codes
  // ---------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_OFF       = 3'h0;
  localparam logic [MODE_W-1:0] MODE_OFF_ALT   = 3'h1;
  localparam logic [MODE_W-1:0] MODE_CMOS      = 3'h2;
  localparam logic [MODE_W-1:0] MODE_CMOS_DIV2 = 3'h3;
  localparam logic [MODE_W-1:0] MODE_RC        = 3'h4;
  localparam logic [MODE_W-1:0] MODE_CAP       = 3'h5;
  localparam logic [MODE_W-1:0] MODE_XTAL      = 3'h6;
  localparam logic [MODE_W-1:0] MODE_XTAL_DIV2 = 3'h7;

  // ---------------------------------------------------------------
  // timer clock divider
  // ---------------------------------------------------------------
  localparam int DIV_RATIO = 8;
  localparam int DIV_W     = $clog2(DIV_RATIO);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN    = 3'b100
  } osc_state_t;

  function automatic logic mode_off(input logic [MODE_W-1:0] m);
    return (m == MODE_OFF) || (m == MODE_OFF_ALT);
  endfunction : mode_off

  function automatic logic mode_xtal(input logic [MODE_W-1:0] m);
    return (m == MODE_XTAL) || (m == MODE_XTAL_DIV2);
  endfunction : mode_xtal

  function automatic logic mode_cmos(input logic [MODE_W-1:0] m);
    return (m == MODE_CMOS) || (m == MODE_CMOS_DIV2);
  endfunction : mode_cmos

  function automatic logic mode_div2(input logic [MODE_W-1:0] m);
    return (m == MODE_CMOS_DIV2) || (m == MODE_XTAL_DIV2);
  endfunction : mode_div2

endpackage : ext_osc_pkg

/* logic/ext_osc_div8.sv */
`timescale 1ns/100ps

module ext_osc_div8
  import ext_osc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clr,
  input  wire logic tick_in,
  output logic      div_clk,
  output logic      div_tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic             tick_reg;

  // ---------------------------------------------------------------
  // count source edges, pulse on wrap
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clr) begin
      cnt_reg  <= DIV_RESET;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_in && (cnt_reg == DIV_LAST);
      if (tick_in) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign div_clk  = cnt_reg[DIV_W-1];
  assign div_tick = tick_reg;

endmodule : ext_osc_div8

/* logic/ext_osc_sync.sv */
`timescale 1ns/100ps

module ext_osc_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // ---------------------------------------------------------------
  // two-stage synchroniser and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;

endmodule : ext_osc_sync

/* logic/external_oscillator_control.sv */
`timescale 1ns/100ps

// How it works
// - mode codes 000 and 001 switch the drive circuit off
// - mode 010 takes a cmos clock, 011 halves it
// - mode 100 runs rc oscillator, 101 runs capacitor oscillator
// - mode 110 runs crystal oscillator, 111 halves the crystal clock
// - top control bit reads 1 once the crystal runs stably
// - valid flag only meaningful in crystal modes, reads 0 otherwise
// - three frequency bits forwarded unchanged to the drive circuit
// - control bit 3 reads zero and ignores writes
// - oscillator clock divided by eight offered to timers, by sixteen in modes 011 and 111
// - timer clock resampled on system clock, jitter within one cycle
// - crystal mode claims both pins, off modes neither, other modes only the second
module external_oscillator_control
  import ext_osc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              amp_clk,
  input  wire logic              osc_out_pin_in,
  input  wire logic              amp_level_ok,
  output logic                   drive_enable,
  output logic      [MODE_W-1:0] drive_mode,
  output logic      [FREQ_W-1:0] drive_freq_ctrl,
  output logic                   osc_in_pin_claim,
  output logic                   osc_out_pin_claim,
  output logic                   ext_clk_out,
  output logic                   timer_clk,
  output logic                   timer_tick,
  output logic                   irq
);

  logic [MODE_W-1:0] mode_reg;
  logic [FREQ_W-1:0] freq_reg;
  logic              valid_reg;
  logic              valid_next;
  logic [EVT_W-1:0]  status_reg;
  logic [EVT_W-1:0]  enable_reg;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] ctrl_view;
  osc_state_t        state_reg;
  osc_state_t        state_next;
  logic              src_raw;
  logic              clk_level;
  logic              clk_rise;
  logic              amp_ok_sync;
  logic              run;
  logic              div2;
  logic              half_reg;
  logic              edge_run;
  logic              ext_clk_reg;
  logic              wr_ctrl;
  logic              wr_clear;
  logic              wr_enable;

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  assign wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_clear  = reg_wr && (reg_addr == OFS_CLEAR);
  assign wr_enable = reg_wr && (reg_addr == OFS_ENABLE);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_reg <= MODE_RESET;
      freq_reg <= FREQ_RESET;
    end else if (wr_ctrl) begin
      mode_reg <= reg_wdata[CTRL_MODE_LSB +: MODE_W];
      freq_reg <= reg_wdata[CTRL_FREQ_LSB +: FREQ_W];
    end
  end

  // ---------------------------------------------------------------
  // drive circuit and pin control
  // ---------------------------------------------------------------
  assign drive_enable      = !mode_off(mode_reg);
  assign drive_mode        = mode_reg;
  assign drive_freq_ctrl   = freq_reg;
  assign osc_in_pin_claim  = mode_xtal(mode_reg);
  assign osc_out_pin_claim = !mode_off(mode_reg);
  assign div2              = mode_div2(mode_reg);

  // ---------------------------------------------------------------
  // clock source select and resampling
  // ---------------------------------------------------------------
  // cmos clock arrives on the second pin, the others from the amplifier
  assign src_raw = mode_cmos(mode_reg) ? osc_out_pin_in : amp_clk;

  // source must not outrun clk_sys or edges are lost
  ext_osc_sync u_clk_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (src_raw),
    .level   (clk_level),
    .rise    (clk_rise)
  );

  ext_osc_sync u_amp_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (amp_level_ok),
    .level   (amp_ok_sync),
    .rise    ()
  );

  // ---------------------------------------------------------------
  // crystal valid flag
  // ---------------------------------------------------------------
  assign valid_next = mode_xtal(mode_reg) && amp_ok_sync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
    end
  end

  // ---------------------------------------------------------------
  // oscillator state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (!mode_off(mode_reg)) begin
          state_next = mode_xtal(mode_reg) ? ST_SETTLE : ST_RUN;
        end
      end
      ST_SETTLE: begin
        if (mode_off(mode_reg)) begin
          state_next = ST_OFF;
        end else if (!mode_xtal(mode_reg) || valid_reg) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mode_off(mode_reg)) begin
          state_next = ST_OFF;
        end else if (mode_xtal(mode_reg) && !valid_reg) begin
          state_next = ST_SETTLE;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign run = (state_reg == ST_RUN);

  // ---------------------------------------------------------------
  // divide-by-two stage and external clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      half_reg <= 1'b0;
    end else if (clk_rise) begin
      half_reg <= ~half_reg;
    end
  end

  assign edge_run = run && clk_rise && (!div2 || !half_reg);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      ext_clk_reg <= 1'b0;
    end else begin
      ext_clk_reg <= div2 ? half_reg : clk_level;
    end
  end

  assign ext_clk_out = ext_clk_reg;

  // ---------------------------------------------------------------
  // timer clock divided by eight
  // ---------------------------------------------------------------
  ext_osc_div8 u_div8 (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clr      (!run),
    .tick_in  (edge_run),
    .div_clk  (timer_clk),
    .div_tick (timer_tick)
  );

  // ---------------------------------------------------------------
  // interrupt status, enable and clear
  // ---------------------------------------------------------------
  always_comb begin
    evt_set = EVT_RESET;
    evt_set[EVT_VALID_BIT] = valid_next && !valid_reg;
    evt_set[EVT_LOST_BIT]  = valid_reg && !valid_next;
    evt_clr = wr_clear ? reg_wdata[EVT_W-1:0] : EVT_RESET;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_reg <= EVT_RESET;
    end else begin
      status_reg <= (status_reg & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      enable_reg <= EVT_RESET;
    end else if (wr_enable) begin
      enable_reg <= reg_wdata[EVT_W-1:0];
    end
  end

  assign irq = |(status_reg & enable_reg);

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_view = CTRL_RESET;
    ctrl_view[CTRL_VALID_BIT] = valid_reg;
    ctrl_view[CTRL_MODE_LSB +: MODE_W] = mode_reg;
    ctrl_view[CTRL_FREQ_LSB +: FREQ_W] = freq_reg;
  end

  always_comb begin
    rdata_next = CTRL_RESET;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:   rdata_next = ctrl_view;
        OFS_STATUS: rdata_next = {{(DATA_W-EVT_W){1'b0}}, status_reg};
        OFS_ENABLE: rdata_next = {{(DATA_W-EVT_W){1'b0}}, enable_reg};
        default:    rdata_next = CTRL_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_reg <= CTRL_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (!rst_n);

  logic [DIV_W-1:0] chk_cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      chk_cnt_reg <= DIV_RESET;
    end else if (edge_run) begin
      chk_cnt_reg <= chk_cnt_reg + 1'b1;
    end
  end

  sequence s_ctrl_write(logic [MODE_W-1:0] m);
    wr_ctrl && (reg_wdata[CTRL_MODE_LSB +: MODE_W] == m);
  endsequence

  sequence s_off_held;
    mode_off(mode_reg) [*2];
  endsequence

  property p_off_drive;
    mode_off(mode_reg) |-> !drive_enable && !osc_out_pin_claim
      && !osc_in_pin_claim;
  endproperty
  a_off_drive: assert property (p_off_drive)
    else $error("drive circuit on in off mode");

  property p_cmos_sel;
    s_ctrl_write(MODE_CMOS_DIV2) |=> drive_enable && div2
      && osc_out_pin_claim && !osc_in_pin_claim;
  endproperty
  a_cmos_sel: assert property (p_cmos_sel)
    else $error("cmos divide mode not applied");

  property p_rc_cap_pins;
    (s_ctrl_write(MODE_RC) or s_ctrl_write(MODE_CAP))
      |=> osc_out_pin_claim && !osc_in_pin_claim && !div2;
  endproperty
  a_rc_cap_pins: assert property (p_rc_cap_pins)
    else $error("rc or capacitor mode pin use wrong");

  property p_xtal_pins;
    mode_xtal(mode_reg) |-> osc_in_pin_claim && osc_out_pin_claim;
  endproperty
  a_xtal_pins: assert property (p_xtal_pins)
    else $error("crystal mode must claim both pins");

  property p_valid_read;
    reg_rd && (reg_addr == OFS_CTRL) && valid_reg
      |=> rdata_reg[CTRL_VALID_BIT];
  endproperty
  a_valid_read: assert property (p_valid_read)
    else $error("valid flag not returned on read");

  property p_valid_mode;
    !mode_xtal(mode_reg) |=> !valid_reg;
  endproperty
  a_valid_mode: assert property (p_valid_mode)
    else $error("valid flag set outside crystal mode");

  property p_freq_fwd;
    wr_ctrl |=> drive_freq_ctrl == $past(reg_wdata[FREQ_W-1:0]);
  endproperty
  a_freq_fwd: assert property (p_freq_fwd)
    else $error("frequency code not forwarded");

  property p_rsvd;
    reg_rd && (reg_addr == OFS_CTRL) |=> !rdata_reg[CTRL_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control bit reads one");

  property p_div8;
    edge_run && (chk_cnt_reg == DIV_LAST) |=> timer_tick;
  endproperty
  a_div8: assert property (p_div8)
    else $error("timer tick missing after eight edges");

  property p_tick_cause;
    timer_tick |-> $past(edge_run && (chk_cnt_reg == DIV_LAST));
  endproperty
  a_tick_cause: assert property (p_tick_cause)
    else $error("timer tick without eighth edge");

  property p_sync_lat;
    $rose(src_raw) |-> ##2 clk_rise;
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("resampled edge not two cycles after source");

  property p_off_quiet;
    s_off_held |=> !ext_clk_out && !timer_clk && !valid_reg;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("clock outputs active in off mode");

  property p_set_wins;
    evt_set[EVT_VALID_BIT] && evt_clr[EVT_VALID_BIT]
      |=> status_reg[EVT_VALID_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("valid event lost under clear");

endmodule : external_oscillator_control

/* test/external_oscillator_control_test.sv */
`timescale 1ns/100ps

module external_oscillator_control_test;
  import ext_osc_pkg::*;

  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              cmos_sel = 1'b0;
  logic              amp_gate = 1'b1;
  logic [3:0]        half_cyc = 4'h1;
  logic              src_clk;
  logic              amp_ok;
  logic              drive_enable;
  logic [MODE_W-1:0] drive_mode;
  logic [FREQ_W-1:0] drive_freq_ctrl;
  logic              osc_in_pin_claim;
  logic              osc_out_pin_claim;
  logic              ext_clk_out;
  logic              timer_clk;
  logic              timer_tick;
  logic              irq;
  logic [DATA_W-1:0] rd_val;
  int                failures = 0;
  int                checks = 0;

  always #50 clk_sys = ~clk_sys;

  external_oscillator_control dut_u (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .amp_clk           (src_clk & ~cmos_sel),
    .osc_out_pin_in    (src_clk & cmos_sel),
    .amp_level_ok      (amp_ok & amp_gate),
    .drive_enable      (drive_enable),
    .drive_mode        (drive_mode),
    .drive_freq_ctrl   (drive_freq_ctrl),
    .osc_in_pin_claim  (osc_in_pin_claim),
    .osc_out_pin_claim (osc_out_pin_claim),
    .ext_clk_out       (ext_clk_out),
    .timer_clk         (timer_clk),
    .timer_tick        (timer_tick),
    .irq               (irq)
  );

  osc_source_model src_u (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (drive_enable),
    .half_cyc (half_cyc),
    .src_clk  (src_clk),
    .amp_ok   (amp_ok)
  );

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_ctrl(logic [2:0] m, logic [2:0] f);
    return {1'b0, m, 1'b0, f};
  endfunction : exp_ctrl

  function automatic logic [7:0] exp_pins(logic [2:0] m);
    return {5'h00, m[2:1] != 2'b00, m[2:1] == 2'b11, m[2:1] != 2'b00};
  endfunction : exp_pins

  function automatic int exp_period(int h, logic [2:0] m);
    return 16 * h * ((m[1] && m[0]) ? 2 : 1);
  endfunction : exp_period

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cycles

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : bus_rd

  task automatic wait_valid();
    cycles(10000);
    for (int i = 0; i < 50; i++) begin
      bus_rd(OFS_CTRL, rd_val);
      if (rd_val[CTRL_VALID_BIT] === 1'b1) return;
    end
    failures++;
    conclude();
  endtask : wait_valid

  task automatic wait_tick();
    for (int i = 0; i < 600; i++) begin
      cycles(1);
      if (timer_tick === 1'b1) return;
    end
    failures++;
    conclude();
  endtask : wait_tick

  task automatic measure(output int per, output int er, output int tr);
    logic pe;
    logic pt;
    per = 0;
    er  = 0;
    tr  = 0;
    pe  = ext_clk_out;
    pt  = timer_clk;
    for (int i = 1; i < 600; i++) begin
      cycles(1);
      if (ext_clk_out === 1'b1 && pe === 1'b0) er++;
      if (timer_clk === 1'b1 && pt === 1'b0) tr++;
      pe = ext_clk_out;
      pt = timer_clk;
      if (timer_tick === 1'b1) begin
        per = i;
        return;
      end
    end
    failures++;
    conclude();
  endtask : measure

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] addrs [5];
    logic [7:0] r;
    logic [2:0] m;
    logic [2:0] f;
    logic [2:0] ofs;
    logic       seen;
    int         per;
    int         er;
    int         tr;
    int         h;
    void'($urandom(32'h38aa));
    addrs = '{OFS_CTRL, OFS_STATUS, OFS_CLEAR, OFS_ENABLE, 4'hF};
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    cycles(1);
    chk("outs", {drive_enable, osc_in_pin_claim, osc_out_pin_claim,
                 ext_clk_out, timer_clk, timer_tick, irq, 1'b0},
        8'h00);
    bus_wr(4'hC, 8'hFF);
    foreach (addrs[i]) begin
      bus_rd(addrs[i], rd_val);
      chk("reset_read", rd_val, 8'h00);
    end
    ofs = 3'($urandom);
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      f = m + ofs;
      r = 8'($urandom);
      bus_wr(OFS_CTRL, {r[7], m, r[3], f});
      bus_rd(OFS_CTRL, rd_val);
      chk("ctrl", rd_val, exp_ctrl(m, f));
      chk("pins", {5'h00, drive_enable, osc_in_pin_claim, osc_out_pin_claim},
          exp_pins(m));
      chk("mode", {5'h00, drive_mode}, {5'h00, m});
      chk("freq", {5'h00, drive_freq_ctrl}, {5'h00, f});
    end
    for (int i = 2; i < 8; i++) begin
      m = 3'(i);
      f = 3'($urandom);
      h = 1 + int'($urandom % 3);
      bus_wr(OFS_CTRL, 8'h00);
      @(posedge clk_sys);
      half_cyc <= 4'(h);
      cmos_sel <= (m[2:1] == 2'b01);
      bus_wr(OFS_CTRL, exp_ctrl(m, f));
      if (m[2:1] == 2'b11) wait_valid();
      wait_tick();
      measure(per, er, tr);
      chk("period", 8'(per), 8'(exp_period(h, m)));
      chk("ext_rises", 8'(er), 8'h08);
      chk("tclk_rises", 8'(tr), 8'h01);
    end
    bus_wr(OFS_CLEAR, 8'h03);
    bus_wr(OFS_ENABLE, 8'h03);
    bus_rd(OFS_STATUS, rd_val);
    chk("status", rd_val, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    @(posedge clk_sys);
    amp_gate <= 1'b0;
    cycles(8);
    bus_rd(OFS_STATUS, rd_val);
    chk("status", rd_val, 8'h02);
    chk("irq", {7'h00, irq}, 8'h01);
    bus_rd(OFS_CTRL, rd_val);
    chk("valid", {7'h00, rd_val[CTRL_VALID_BIT]}, 8'h00);
    bus_wr(OFS_ENABLE, 8'h01);
    cycles(1);
    chk("irq", {7'h00, irq}, 8'h00);
    bus_wr(OFS_STATUS, 8'hFF);
    bus_rd(OFS_STATUS, rd_val);
    chk("status", rd_val, 8'h02);
    bus_rd(OFS_ENABLE, rd_val);
    chk("enable", rd_val, 8'h01);
    bus_wr(OFS_CLEAR, 8'h02);
    bus_rd(OFS_STATUS, rd_val);
    chk("status", rd_val, 8'h00);
    @(posedge clk_sys);
    amp_gate <= 1'b1;
    @(posedge clk_sys);
    // clear lands in the cycle the valid event sets: set must win
    bus_wr(OFS_CLEAR, 8'h01);
    cycles(8);
    bus_rd(OFS_STATUS, rd_val);
    chk("status", rd_val, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    bus_rd(OFS_CLEAR, rd_val);
    chk("clear", rd_val, 8'h00);
    bus_wr(OFS_CLEAR, 8'h01);
    cycles(1);
    chk("irq", {7'h00, irq}, 8'h00);
    bus_wr(OFS_CTRL, {1'b1, MODE_OFF_ALT, 1'b1, 3'h5});
    cycles(3);
    seen = 1'b0;
    for (int i = 0; i < 40; i++) begin
      cycles(1);
      seen = seen | timer_tick | ext_clk_out | timer_clk;
    end
    chk("off_clk", {7'h00, seen}, 8'h00);
    chk("off_pins", {5'h00, drive_enable, osc_in_pin_claim, osc_out_pin_claim},
        8'h00);
    bus_rd(OFS_CTRL, rd_val);
    chk("off_ctrl", rd_val, 8'h15);
    conclude();
  end
endmodule : external_oscillator_control_test

/* test/osc_source_model.sv */
`timescale 1ns/100ps

module osc_source_model #(
  parameter int SETTLE_CYC = 40
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] half_cyc,
  output logic            src_clk,
  output logic            amp_ok
);
  int cnt;
  int settle;

  // ---------------------------------------------------------------
  // source clock, still while the drive circuit is off
  // ---------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (!rst_n || !run) begin
      src_clk <= 1'b0;
      cnt     <= 0;
    end else if (cnt >= int'(half_cyc) - 1) begin
      src_clk <= ~src_clk;
      cnt     <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // amplitude detector settles some time after enable
  // ---------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (!rst_n || !run) begin
      settle <= 0;
      amp_ok <= 1'b0;
    end else if (settle < SETTLE_CYC) begin
      settle <= settle + 1;
    end else begin
      amp_ok <= 1'b1;
    end
  end
endmodule : osc_source_model
